// File: rlc_params.svh
// Constants for the rotate-left-through-carry datapath.
// Assumes a 12-bit data address: a 4-bit bank above an 8-bit offset.
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH

`define RLC_DATA_W 8
`define RLC_BANK_W 4
`define RLC_ADDR_W 12
`define RLC_MSB 7
`define RLC_DEST_WREG 1'b0
`define RLC_DEST_FILE 1'b1
`define RLC_ACCESS_SHARED 1'b0
`define RLC_ACCESS_BANKED 1'b1
`define RLC_ACCESS_SPLIT 8'h80
`define RLC_ACCESS_LO_BANK 4'h0
`define RLC_ACCESS_HI_BANK 4'hf
`define RLC_RESET_BYTE 8'h00
`define RLC_RESET_ADDR 12'h000

`endif

// File: rlc_pkg.sv
// Types for the rotate-left-through-carry datapath.
// Assumes rlc_params.svh is on the include path.
`include "rlc_params.svh"

package rlc_pkg;

    typedef logic [`RLC_DATA_W-1:0] rlc_byte_t;
    typedef logic [`RLC_ADDR_W-1:0] rlc_addr_t;
    typedef logic [`RLC_BANK_W-1:0] rlc_bank_t;

    typedef enum logic [4:0] {
        RLC_IDLE    = 5'b00001,
        RLC_DECODE  = 5'b00010,
        RLC_READ    = 5'b00100,
        RLC_PROCESS = 5'b01000,
        RLC_WRITE   = 5'b10000
    } rlc_phase_t;

endpackage

// File: rlc_alu_if.sv
// Carrier between the phase sequencer and the rotate unit.
// Assumes both ends share one clock; the path is purely combinational.
`timescale 1ns/1ps

interface rlc_alu_if;
    import rlc_pkg::*;
    rlc_byte_t operand;
    logic carry_in;
    rlc_byte_t result;
    logic carry_out;
    logic negative;
    logic zero;

    modport seq (output operand, output carry_in,
                 input result, input carry_out, input negative, input zero);
    modport alu (input operand, input carry_in,
                 output result, output carry_out, output negative, output zero);
endinterface

// File: rlc_rotate_unit.sv
// Combinational rotate of one byte left through carry, with flags.
// Assumes the sequencer registers whatever it takes from here.
`timescale 1ns/1ps

module rlc_rotate_unit
    import rlc_pkg::*;
(
    rlc_alu_if.alu alu
);

    assign alu.result = {alu.operand[`RLC_MSB-1:0], alu.carry_in};
    assign alu.carry_out = alu.operand[`RLC_MSB];

    assign alu.negative = alu.result[`RLC_MSB];
    assign alu.zero = (alu.result == `RLC_RESET_BYTE);

endmodule

// File: rlc_rotate_left_carry_op.sv
// Four-phase sequencer for the rotate-left-through-carry instruction.
// Assumes a data memory that answers a read in the same cycle and a
// core that holds the instruction fields steady while start_i is high.
`timescale 1ns/1ps

module rlc_rotate_left_carry_op
    import rlc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] file_addr_i,
    input wire logic dest_sel_i,
    input wire logic access_sel_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic carry_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [11:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic wreg_wr_o,
    output logic [7:0] wreg_data_o,
    output logic flags_wr_o,
    output logic carry_o,
    output logic negative_o,
    output logic zero_o,
    output logic [4:0] phase_o,
    output logic busy_o,
    output logic done_o
);

    rlc_phase_t phase_ff, nxt_phase;
    rlc_addr_t addr_ff, nxt_addr;
    logic dest_ff, nxt_dest;
    rlc_byte_t operand_ff, nxt_operand;
    rlc_byte_t result_ff, nxt_result;
    logic carry_ff, nxt_carry;
    logic negative_ff, nxt_negative;
    logic zero_ff, nxt_zero;

    rlc_alu_if alu_bus ();

    rlc_rotate_unit u_rotate (
        .alu(alu_bus.alu)
    );

    function automatic rlc_addr_t rlc_eff_addr(input logic access_sel, input rlc_byte_t offset,
                                               input rlc_bank_t bank);
        rlc_bank_t use_bank;
        use_bank = bank;
        if (access_sel == `RLC_ACCESS_SHARED) begin
            if (offset < `RLC_ACCESS_SPLIT) begin
                use_bank = `RLC_ACCESS_LO_BANK;
            end else begin
                use_bank = `RLC_ACCESS_HI_BANK;
            end
        end
        rlc_eff_addr = {use_bank, offset};
    endfunction

    assign alu_bus.operand = operand_ff;
    assign alu_bus.carry_in = carry_i;

    // Phase sequencing
    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            RLC_IDLE: begin
                if (start_i) begin
                    nxt_phase = RLC_DECODE;
                end
            end
            RLC_DECODE: begin
                nxt_phase = RLC_READ;
            end
            RLC_READ: begin
                nxt_phase = RLC_PROCESS;
            end
            RLC_PROCESS: begin
                nxt_phase = RLC_WRITE;
            end
            RLC_WRITE: begin
                if (start_i) begin
                    nxt_phase = RLC_DECODE;
                end else begin
                    nxt_phase = RLC_IDLE;
                end
            end
            default: begin
                nxt_phase = RLC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_ff <= RLC_IDLE;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // Datapath
    always_comb begin
        nxt_addr = addr_ff;
        nxt_dest = dest_ff;
        nxt_operand = operand_ff;
        nxt_result = result_ff;
        nxt_carry = carry_ff;
        nxt_negative = negative_ff;
        nxt_zero = zero_ff;
        if (nxt_phase == RLC_DECODE) begin
            nxt_addr = rlc_eff_addr(access_sel_i, file_addr_i, bank_select_reg_i);
            nxt_dest = dest_sel_i;
        end
        if (phase_ff == RLC_READ) begin
            nxt_operand = mem_rdata_i;
        end
        if (phase_ff == RLC_PROCESS) begin
            nxt_result = alu_bus.result;
            nxt_carry = alu_bus.carry_out;
            nxt_negative = alu_bus.negative;
            nxt_zero = alu_bus.zero;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            addr_ff <= `RLC_RESET_ADDR;
            dest_ff <= `RLC_DEST_FILE;
            operand_ff <= `RLC_RESET_BYTE;
            result_ff <= `RLC_RESET_BYTE;
            carry_ff <= 1'b0;
            negative_ff <= 1'b0;
            zero_ff <= 1'b0;
        end else begin
            addr_ff <= nxt_addr;
            dest_ff <= nxt_dest;
            operand_ff <= nxt_operand;
            result_ff <= nxt_result;
            carry_ff <= nxt_carry;
            negative_ff <= nxt_negative;
            zero_ff <= nxt_zero;
        end
    end

    // Memory and register strobes
    assign mem_addr_o = addr_ff;
    assign mem_rd_o = (phase_ff == RLC_READ);
    assign mem_wr_o = (phase_ff == RLC_WRITE) && (dest_ff == `RLC_DEST_FILE);
    assign mem_wdata_o = result_ff;
    assign wreg_wr_o = (phase_ff == RLC_WRITE) && (dest_ff == `RLC_DEST_WREG);
    assign wreg_data_o = result_ff;
    assign flags_wr_o = (phase_ff == RLC_WRITE);
    assign carry_o = carry_ff;
    assign negative_o = negative_ff;
    assign zero_o = zero_ff;
    assign phase_o = phase_ff;
    assign busy_o = (phase_ff != RLC_IDLE);
    assign done_o = (phase_ff == RLC_WRITE);

endmodule

// File: rlc_mem_model.sv
// Data memory at the far side of the datapath.
// Assumes same-cycle reads and writes on the clock edge.
`timescale 1ns/1ps
module rlc_mem_model
    import rlc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire rlc_addr_t addr_i,
    input wire rlc_byte_t wdata_i,
    output rlc_byte_t rdata_o
);
    rlc_byte_t mem [4096];
    initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
    // No stale data while unread
    assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
    always @(posedge sys_clk_i) if (wr_i) mem[addr_i] <= wdata_i;
endmodule

// File: rlc_rotate_left_carry_op_assertions.sv
// Port checks for the rotate datapath.
// Assumes the bind below attaches it.
`timescale 1ns/1ps
module rlc_rotate_left_carry_op_assertions
    import rlc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] file_addr_i,
    input wire logic dest_sel_i,
    input wire logic access_sel_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic carry_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [11:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic wreg_wr_o,
    input wire logic flags_wr_o,
    input wire logic carry_o,
    input wire logic negative_o,
    input wire logic zero_o,
    input wire logic [4:0] phase_o,
    input wire logic done_o
);
    logic take;
    rlc_addr_t ea;
    rlc_byte_t rd_q;
    assign take = start_i && (phase_o == RLC_IDLE || phase_o == RLC_WRITE);
    assign ea = access_sel_i ? {bank_select_reg_i, file_addr_i} : {file_addr_i[7] ? 4'hf : 4'h0, file_addr_i};
    always_ff @(posedge sys_clk_i) if (mem_rd_o) rd_q <= mem_rdata_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_read_timing: assert property (take |-> ##2 mem_rd_o)
        else $error("read late");
    a_write_timing: assert property (take |-> ##4 (done_o && flags_wr_o))
        else $error("write late");
    a_phase_order: assert property (phase_o == RLC_DECODE |=> phase_o == RLC_READ ##1
        phase_o == RLC_PROCESS ##1 phase_o == RLC_WRITE) else $error("phase order");
    a_dest_route: assert property (done_o |-> mem_wr_o == $past(dest_sel_i, 4)
        && wreg_wr_o == !mem_wr_o) else $error("wrong destination");
    a_rotate_data: assert property (done_o |-> mem_wdata_o == {rd_q[6:0], $past(carry_i)}
        && carry_o == rd_q[7]) else $error("rotate value");
    a_flag_values: assert property (flags_wr_o |-> negative_o == mem_wdata_o[7]
        && zero_o == (mem_wdata_o == 8'h00)) else $error("flags");
    a_bank_addr: assert property (done_o |-> mem_addr_o == $past(ea, 4))
        else $error("address");
    a_done_gap: assert property (done_o |=> !done_o [*3])
        else $error("done spacing");
endmodule
bind rlc_rotate_left_carry_op rlc_rotate_left_carry_op_assertions u_chk (.*);

// File: tb_top.sv
// Self-checking bench for the rotate datapath.
// Assumes the checker is bound and the memory model answers reads.
`timescale 1ns/1ps
module tb_top;
    import rlc_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, start_i = 0, dest_sel_i = 0, access_sel_i = 0, carry_i = 0;
    logic [7:0] file_addr_i = 8'h00;
    logic [3:0] bank_select_reg_i = 4'h0;
    rlc_byte_t mem_rdata_i, mem_wdata_o, wreg_data_o;
    rlc_addr_t mem_addr_o;
    logic mem_rd_o, mem_wr_o, wreg_wr_o, flags_wr_o, carry_o, negative_o, zero_o, busy_o, done_o;
    logic [4:0] phase_o;
    int miscompares = 0, check_count = 0;
    int ref_mem [4096];
    logic [15:0] r = 16'h0033;
    `define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
        $display("mismatch %s exp %h got %h", n, e, s); end end
    rlc_rotate_left_carry_op u_rlc_rotate_left_carry_op (.*);
    rlc_mem_model u_rlc_mem_model (.sys_clk_i(sys_clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic op(input logic gap);
        int a, v;
        logic [7:0] x;
        r = lfsr(r);
        a = r[9] ? {r[13:10] & 4'h1, r[7:0] & 8'h83} : {r[7] ? 4'hf : 4'h0, r[7:0] & 8'h83};
        v = ref_mem[a];
        x = {v[6:0], r[14]};
        start_i <= 1;
        file_addr_i <= r[7:0] & 8'h83;
        dest_sel_i <= r[8];
        access_sel_i <= r[9];
        bank_select_reg_i <= r[13:10] & 4'h1;
        carry_i <= r[14];
        @(posedge sys_clk_i);
        start_i <= r[15];
        @(posedge sys_clk_i);
        start_i <= 0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK("addr", 12'(a), mem_addr_o)
        `CHK("file wr", r[8], mem_wr_o)
        `CHK("wreg wr", !r[8], wreg_wr_o)
        `CHK("data", x, r[8] ? mem_wdata_o : wreg_data_o)
        `CHK("carry", v[7], carry_o)
        `CHK("flags", {1'b1, x[7], x == 8'h00}, {flags_wr_o, negative_o, zero_o})
        `CHK("done", 1'b1, done_o)
        `CHK("busy", 1'b1, busy_o)
        `CHK("write phase", 5'h10, phase_o)
        if (r[8]) ref_mem[a] = x;
        if (gap) @(posedge sys_clk_i);
    endtask
    initial forever #20 sys_clk_i = ~sys_clk_i;
    initial begin
        #40000;
        miscompares++;
        stop_test();
    end
    initial begin
        for (int i = 0; i < 4096; i++) ref_mem[i] = i & 8'hff;
        repeat (10) @(posedge sys_clk_i);
        `CHK("reset phase", 5'h01, phase_o)
        rst_i <= 0;
        for (int k = 0; k < 80; k++) op(r[0]);
        $display("test rotate ended");
        stop_test();
    end
endmodule
